// ---- dv/host_model.sv ----
// Purpose: host side that takes measurement and special datagrams
// Assumes: tx_ready is a level, dg_valid and spec_valid are pulses
// Notes: stall makes the host refuse datagrams
`timescale 1ns/1ps
`default_nettype none
module host_model (
    input wire logic clk,
    input wire logic stall,
    input wire logic dg_valid,
    input wire logic spec_valid,
    output logic tx_ready,
    output var int n_dg,
    output var int n_spec
);
    assign tx_ready = !stall;
    initial n_dg = 0;
    initial n_spec = 0;
    always @(posedge clk)
    begin
        if (dg_valid === 1'b1)
            n_dg <= n_dg + 1;
        if (spec_valid === 1'b1)
            n_spec <= n_spec + 1;
    end
endmodule
`default_nettype wire

// ---- dv/testbench.sv ----
// Purpose: self-checking bench for the rate sensor output stage
// Assumes: short tick of 20 cycles, start-up of 5 ticks
// Notes: registers reached through AXI4-Lite tasks
`timescale 1ns/1ps
`default_nettype none
`include "gyro_out_consts.svh"
module testbench;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic awv = 1'b0, wv = 1'b0, bre = 1'b0, arv = 1'b0, rre = 1'b0;
    logic [7:0] awa = 8'h00, ara = 8'h00;
    logic [31:0] wd = 32'h0;
    logic awr, wr, bv, arr, rv, txr, dgv, spv;
    logic [1:0] br, rr, ssel, r;
    logic [31:0] rd, v;
    gyro_out_pkg::axes_t rate = {24'h001000, 24'h002000, 24'h004000};
    gyro_out_pkg::dgram_t dg;
    logic [2:0] rok = 3'h7;
    logic [79:0] flt = 80'h0, ew;
    logic ini = 1'b0, sen = 1'b0, sex = 1'b0, rei = 1'b0, trg = 1'b1, stall = 1'b0, wrp = 1'b0;
    logic [23:0] dl;
    int n_dg, n_spec, k, mismatches = 0, n_checks = 0, cyc = 0;
    logic [5:0] sseq = 6'h00;
    always #5 clk = ~clk;
    // Order of special datagram selectors
    always @(posedge clk)
    begin
        if (spv === 1'b1)
            sseq <= {sseq[3:0], ssel};
    end
    gyro_output_stage #(.SAMPLE_CYC(20), .STARTUP_MS(5)) i_gyro_output_stage (.clk(clk), .rst_n(rst_n),
        .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_awaddr(awa), .s_axi_wvalid(wv), .s_axi_wready(wr),
        .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_bvalid(bv), .s_axi_bready(bre), .s_axi_bresp(br),
        .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_araddr(ara), .s_axi_rvalid(rv), .s_axi_rready(rre),
        .s_axi_rdata(rd), .s_axi_rresp(rr), .rate_in(rate), .rate_ok(rok), .fault_in(flt), .init_done(ini),
        .svc_enter(sen), .svc_exit(sex), .reinit(rei), .trig_n_pin(trg), .tx_ready(txr), .dg_valid(dgv),
        .dg(dg), .spec_valid(spv), .spec_sel(ssel), .err_word(ew));
    host_model i_host_model (.clk(clk), .stall(stall), .dg_valid(dgv), .spec_valid(spv), .tx_ready(txr),
        .n_dg(n_dg), .n_spec(n_spec));
    // Reference CRC-8, x^8+x^2+x+1, seed all ones, MSB first
    function automatic logic [7:0] crc(input logic [87:0] d);
        crc = 8'hff;
        for (int i = 87; i >= 0; i--)
            crc = {crc[6:0], 1'b0} ^ ((crc[7] ^ d[i]) ? 8'h07 : 8'h00);
    endfunction
    task results;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task chk(input string s, input logic [79:0] e, input logic [79:0] g);
        n_checks++;
        if (g !== e)
        begin
            mismatches++;
            $display("BAD %s exp %h got %h", s, e, g);
        end
    endtask
    task axw(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        awv <= 1'b1; wv <= 1'b1; awa <= a; wd <= d; bre <= 1'b1;
        do
        begin
            @(posedge clk);
            if (awr) awv <= 1'b0;
            if (wr) wv <= 1'b0;
        end while (bv !== 1'b1);
        r = br;
        bre <= 1'b0;
    endtask
    task axr(input logic [7:0] a);
        @(posedge clk);
        arv <= 1'b1; ara <= a; rre <= 1'b1;
        do
        begin
            @(posedge clk);
            if (arr) arv <= 1'b0;
        end while (rv !== 1'b1);
        v = rd;
        r = rr;
        rre <= 1'b0;
    endtask
    // Wait for datagram count, bounded by the run limit
    task wdg(input int n);
        while (n_dg < n) @(posedge clk);
    endtask
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            mismatches = mismatches + 1;
            results;
        end
    end
    initial
    begin
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        axr(`A_DIV); chk("div reset", `DIV_RST, v);
        axr(8'h3c); chk("rd resp", 2'h2, r);
        chk("rd data", 32'h0, v);
        axw(8'h3c, 32'h1); chk("wr resp", 2'h2, r);
        flt <= {80{1'b1}};
        rok <= 3'h1;
        repeat (3) @(posedge clk);
        chk("reserved", 80'h0, ew & `ERR_RSV_MASK);
        chk("tx fail idle", 1'b0, ew[55]);
        chk("missing", 3'h6, ew[54:52]);
        chk("overflow", 6'h3f, {ew[39:38], ew[32:31], ew[25:24]});
        chk("temp", 3'h7, ew[6:4]);
        axr(`A_EHDR); chk("err id", 8'h2e, v[7:0]);
        chk("err crc", crc({8'h2e, ew}), v[15:8]);
        axw(`A_CTRL, 32'h8);
        axr(`A_EHDR); chk("err id term", 8'h2f, v[7:0]);
        chk("err crc term", crc({8'h2f, ew}), v[15:8]);
        flt <= 80'h0;
        rok <= 3'h7;
        axw(`A_DIV, 32'h1);
        @(posedge clk) ini <= 1'b1;
        @(posedge clk) ini <= 1'b0;
        wdg(1); chk("specials", 3, n_spec);
        chk("spec order", 6'h06, sseq);
        chk("startup on", 1'b1, dg.status[6]);
        chk("rate", 72'(rate), dg.val);
        wdg(9); chk("status", 8'h0, dg.status);
        axw(`A_DIV, 32'h2);
        axw(`A_CTRL, 32'h1);
        wdg(n_dg + 3); chk("inc x", 24'(2 * 4096 * 128 / 1000), dg.val.x);
        chk("inc z", 24'(2 * 16384 * 128 / 1000), dg.val.z);
        axw(`A_CTRL, 32'h2);
        wdg(n_dg + 3); chk("avg", 24'h001000, dg.val.x);
        axw(`A_DIV, 32'h1);
        axw(`A_CTRL, 32'h3);
        rate.x <= 24'h7fffff;
        wdg(n_dg + 2);
        for (k = 0; k < 20; k++)
        begin
            v = dg.val.x;
            wdg(n_dg + 1);
            dl = dg.val.x - v[23:0];
            if (v[23] == 1'b0 && dg.val.x[23] == 1'b1) wrp = 1'b1;
            chk("int step", 1'b1, dl == 24'd1073741 || dl == 24'd1073742);
            chk("int status", 8'h0, dg.status);
        end
        chk("wrapped", 1'b1, wrp);
        stall <= 1'b1;
        k = n_dg;
        repeat (50) @(posedge clk);
        chk("tx fail", 1'b1, ew[55]);
        chk("stalled", k, n_dg);
        stall <= 1'b0;
        axw(`A_CTRL, 32'h4);
        @(posedge clk) sen <= 1'b1;
        @(posedge clk) sen <= 1'b0;
        k = n_dg;
        @(posedge clk) trg <= 1'b0;
        repeat (10) @(posedge clk);
        trg <= 1'b1;
        repeat (20) @(posedge clk);
        chk("service", k, n_dg);
        @(posedge clk) sex <= 1'b1;
        @(posedge clk) sex <= 1'b0;
        trg <= 1'b0;
        wdg(k + 1); chk("no startup", 1'b0, dg.status[6]);
        chk("latency", 16'h0, dg.latency);
        repeat (40) @(posedge clk) trg <= 1'b1;
        chk("one per edge", k + 1, n_dg);
        @(posedge clk) trg <= 1'b0;
        @(posedge clk) trg <= 1'b1;
        repeat (30) @(posedge clk);
        chk("glitch", k + 1, n_dg);
        @(posedge clk) rei <= 1'b1;
        @(posedge clk) rei <= 1'b0;
        axr(`A_STAT); chk("reinit", 5'h00, v[4:0]);
        @(posedge clk) ini <= 1'b1;
        @(posedge clk) ini <= 1'b0;
        repeat (5) @(posedge clk);
        chk("trig specials", 6, n_spec);
        chk("trig no dg", k + 1, n_dg);
        results;
    end
endmodule
`default_nettype wire

// ---- hw/gyro_out_consts.svh ----
// Purpose: constants for the rate sensor output stage
// Assumes: 100 MHz clock, 32-bit AXI4-Lite register port
// Notes: byte addresses, field positions, reset values, counts
// Behaviour
// RULE_01 - 80-bit error word, reserved bits zero
// RULE_02 - bit 55 when transmitter cannot send
// RULE_03 - missing data bits 54 Z, 53 Y, 52 X
// RULE_04 - converter overflow I/Q bits per axis
// RULE_05 - temperature error bits 6, 5, 4
// RULE_06 - start-up period sets status bit 6
// RULE_07 - keep sending during start-up period
// RULE_08 - service exit skips start-up period
// RULE_09 - only falling trigger edge counts
// RULE_10 - one datagram per trigger edge
// RULE_11 - three special datagrams after initialisation
// RULE_12 - service mode ignores trigger input
// RULE_13 - latency from sample ready to edge
// RULE_14 - incremental: sum of samples times 1ms
// RULE_15 - average: mean of samples since send
// RULE_16 - integrated angle never cleared on send
// RULE_17 - integrated angle wraps at four degrees
// RULE_18 - internal samples fixed at 1000 per second
// RULE_19 - rate output sends latest sample only
// RULE_20 - rate: 24-bit, 2^14 counts per deg/s
// RULE_21 - angle: 24-bit, 2^21 counts per degree
// RULE_22 - status describes current datagram only
// RULE_23 - error header 0x2E/0x2F, CRC-8 seed 0xFF
// RULE_24 - trigger synchronised, two stable samples
// RULE_25 - clear sum accumulators after each send
`ifndef GYRO_OUT_CONSTS_SVH
`define GYRO_OUT_CONSTS_SVH
`define CLK_HZ 100000000
`define SAMPLE_HZ 1000
`define SAMPLE_CYC (`CLK_HZ / `SAMPLE_HZ)
`define CLK_NS 10
`define US_NS 1000
`define US_CYC (`US_NS / `CLK_NS)
`define STARTUP_MS 1000
`define ANGLE_SHIFT 7
`define MS_DIV 1000
`define SPECIAL_COUNT 2'h3
`define LAT_MAX 16'hffff
`define ERR_RSV_MASK 80'hfffff00003060c000000
`define ERR_TX_FAIL 55
`define ERR_MISS_Z 54
`define ERR_MISS_Y 53
`define ERR_MISS_X 52
`define ERR_ID_PLAIN 8'h2e
`define ERR_ID_TERM 8'h2f
`define CRC_SEED 8'hff
`define CRC_POLY 8'h07
`define STAT_STARTUP 6
`define STAT_ERR 7
`define DIV_RST 10'h004
`define A_CTRL 8'h00
`define A_DIV 8'h04
`define A_STAT 8'h08
`define A_LAT 8'h0c
`define A_X 8'h10
`define A_Y 8'h14
`define A_Z 8'h18
`define A_ERR0 8'h1c
`define A_ERR1 8'h20
`define A_ERR2 8'h24
`define A_EHDR 8'h28
`endif

// ---- hw/gyro_out_pkg.sv ----
// Purpose: shared types for the rate sensor output stage
// Assumes: constants live in gyro_out_consts.svh
// Notes: carriers are packed structs
package gyro_out_pkg;
    typedef enum logic [1:0] {
        UNIT_RATE = 2'b00,
        UNIT_INC = 2'b01,
        UNIT_AVG = 2'b10,
        UNIT_INT = 2'b11
    } out_unit_t;
    typedef enum logic [1:0] {
        MODE_INIT = 2'b00,
        MODE_NORMAL = 2'b01,
        MODE_SERVICE = 2'b10
    } mode_t;
    typedef struct packed {
        logic signed [23:0] x;
        logic signed [23:0] y;
        logic signed [23:0] z;
    } axes_t;
    typedef struct packed {
        axes_t val;
        logic [7:0] status;
        logic [15:0] latency;
    } dgram_t;
endpackage

// ---- hw/gyro_output_stage.sv ----
// Purpose: output stage of a three-axis rate sensor in measuring mode
// Assumes: rate samples and fault flags come from logic on clk
// Notes: datagram framing and serial protocol live elsewhere
//
// Implementation choices: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "gyro_out_consts.svh"
module gyro_output_stage #(
    parameter int SAMPLE_CYC = `SAMPLE_CYC,
    parameter int STARTUP_MS = `STARTUP_MS
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    output logic [1:0] s_axi_bresp,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    input wire logic [7:0] s_axi_araddr,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    input wire gyro_out_pkg::axes_t rate_in,
    input wire logic [2:0] rate_ok,
    input wire logic [79:0] fault_in,
    input wire logic init_done,
    input wire logic svc_enter,
    input wire logic svc_exit,
    input wire logic reinit,
    input wire logic trig_n_pin,
    input wire logic tx_ready,
    output logic dg_valid,
    output gyro_out_pkg::dgram_t dg,
    output logic spec_valid,
    output logic [1:0] spec_sel,
    output logic [79:0] err_word
);
    localparam int STARTUP_TICKS = STARTUP_MS;
    gyro_out_pkg::mode_t mode;
    logic [1:0] unit;
    logic trig_en;
    logic term_en;
    logic [9:0] out_div;
    logic [16:0] tick_cnt;
    logic tick;
    logic tick_d;
    logic [6:0] us_cnt;
    logic [15:0] lat_cnt;
    logic [15:0] startup_left;
    logic startup;
    logic [1:0] spec_left;
    logic s1;
    logic s2;
    logic s3;
    logic trig_st;
    logic trig_fall;
    logic [9:0] div_cnt;
    logic [15:0] samp_n;
    logic send;
    logic tx_free;
    logic signed [23:0] rin [3];
    logic signed [23:0] last [3];
    logic signed [39:0] acc [3];
    logic signed [23:0] integ [3];
    logic signed [15:0] rem [3];
    logic signed [23:0] next_integ [3];
    logic signed [15:0] next_rem [3];
    logic signed [23:0] sel [3];
    logic [79:0] next_err;
    logic [7:0] err_crc;
    logic aw_hold;
    logic w_hold;
    logic [7:0] aw_q;
    logic [31:0] wd_q;
    logic [3:0] ws_q;
    logic wr_go;

    function automatic logic signed [23:0] to_angle(input logic signed [39:0] s);
        logic signed [55:0] w;
        w = {{16{s[39]}}, s} <<< `ANGLE_SHIFT;
        to_angle = 24'(w / 56'sd1000);
    endfunction

    // Value placed in the datagram for the chosen output unit
    function automatic logic signed [23:0] pick(
        input logic [1:0] u,
        input logic signed [39:0] a,
        input logic [15:0] n,
        input logic signed [23:0] l,
        input logic signed [23:0] g
    );
        pick = l;
        case (u)
            gyro_out_pkg::UNIT_RATE: pick = l; // see RULE_19 see RULE_20
            gyro_out_pkg::UNIT_INC: pick = to_angle(a); // see RULE_14 see RULE_21
            gyro_out_pkg::UNIT_AVG:
            begin
                if (n != 16'h0000)
                    pick = 24'(a / $signed({24'h000000, n})); // see RULE_15
            end
            gyro_out_pkg::UNIT_INT: pick = g; // see RULE_16
            default: pick = l;
        endcase
    endfunction

    function automatic logic [7:0] crc8(input logic [87:0] d);
        logic [7:0] c;
        c = `CRC_SEED;
        for (int i = 87; i >= 0; i--)
        begin
            if (c[7] ^ d[i])
                c = (c << 1) ^ `CRC_POLY;
            else
                c = c << 1;
        end
        crc8 = c;
    endfunction

    assign rin[0] = rate_in.x;
    assign rin[1] = rate_in.y;
    assign rin[2] = rate_in.z;
    assign tick = (tick_cnt == 17'(SAMPLE_CYC - 1));
    assign startup = (startup_left != 16'h0000);
    assign tx_free = tx_ready && (spec_left == 2'h0);
    // Stable level only changes when second and third stage agree
    assign trig_fall = trig_st && (s2 == s3) && !s2; // see RULE_09 see RULE_24

    always_comb
    begin
        send = 1'b0;
        if (mode == gyro_out_pkg::MODE_NORMAL) // see RULE_12 see RULE_07
        begin
            if (trig_en)
                send = trig_fall; // see RULE_10
            else
                send = tick_d && (div_cnt >= ((out_div == 10'h000) ? 10'h001 : out_div));
        end
    end

    // Fixed internal sample tick
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tick_cnt <= 17'h00000;
            tick_d <= 1'b0;
        end
        else
        begin
            tick_cnt <= tick ? 17'h00000 : tick_cnt + 17'h00001; // see RULE_18
            tick_d <= tick;
        end
    end

    // Microseconds since the last finished sample
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            us_cnt <= 7'h00;
            lat_cnt <= 16'h0000;
        end
        else if (tick)
        begin
            us_cnt <= 7'h00;
            lat_cnt <= 16'h0000; // see RULE_13
        end
        else if (us_cnt == 7'(`US_CYC - 1))
        begin
            us_cnt <= 7'h00;
            if (lat_cnt != `LAT_MAX)
                lat_cnt <= lat_cnt + 16'h0001;
        end
        else
            us_cnt <= us_cnt + 7'h01;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s1 <= 1'b1;
            s2 <= 1'b1;
            s3 <= 1'b1;
            trig_st <= 1'b1;
        end
        else
        begin
            s1 <= trig_n_pin;
            s2 <= s1;
            s3 <= s2;
            if (s2 == s3)
                trig_st <= s2; // see RULE_24
        end
    end

    // Operating mode and start-up period
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mode <= gyro_out_pkg::MODE_INIT;
            startup_left <= 16'h0000;
            spec_left <= 2'h0;
        end
        else
        begin
            if (spec_left != 2'h0 && tx_ready)
                spec_left <= spec_left - 2'h1;
            if (reinit)
            begin
                mode <= gyro_out_pkg::MODE_INIT;
                startup_left <= 16'h0000;
            end
            else
            begin
                case (mode)
                    gyro_out_pkg::MODE_INIT:
                    begin
                        if (init_done)
                        begin
                            mode <= gyro_out_pkg::MODE_NORMAL;
                            startup_left <= 16'(STARTUP_TICKS); // see RULE_06
                            spec_left <= `SPECIAL_COUNT; // see RULE_11
                        end
                    end
                    gyro_out_pkg::MODE_NORMAL:
                    begin
                        if (svc_enter)
                            mode <= gyro_out_pkg::MODE_SERVICE;
                        else if (tick && startup)
                            startup_left <= startup_left - 16'h0001;
                    end
                    gyro_out_pkg::MODE_SERVICE:
                    begin
                        if (svc_exit)
                        begin
                            mode <= gyro_out_pkg::MODE_NORMAL;
                            startup_left <= 16'h0000; // see RULE_08
                        end
                    end
                    default: mode <= gyro_out_pkg::MODE_INIT;
                endcase
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            spec_valid <= 1'b0;
            spec_sel <= 2'h0;
        end
        else
        begin
            spec_valid <= (spec_left != 2'h0) && tx_ready; // see RULE_11
            spec_sel <= `SPECIAL_COUNT - spec_left;
        end
    end

    // Integrated angle carries the sub-count remainder forward
    always_comb
    begin
        for (int i = 0; i < 3; i++)
        begin
            logic signed [47:0] t;
            logic signed [47:0] q;
            t = 48'(({{24{rin[i][23]}}, rin[i]} <<< `ANGLE_SHIFT)) + 48'(rem[i]);
            q = t / 48'sd1000;
            next_rem[i] = 16'(t - q * 48'sd1000);
            next_integ[i] = integ[i] + q[23:0]; // see RULE_17
            sel[i] = pick(unit, acc[i], samp_n, last[i], integ[i]);
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            div_cnt <= 10'h000;
            samp_n <= 16'h0000;
            for (int i = 0; i < 3; i++)
            begin
                last[i] <= 24'sh000000;
                acc[i] <= 40'sh0000000000;
                integ[i] <= 24'sh000000;
                rem[i] <= 16'sh0000;
            end
        end
        else
        begin
            if (send)
                div_cnt <= 10'h000;
            else if (tick)
                div_cnt <= div_cnt + 10'h001;
            if (send)
                samp_n <= tick ? 16'h0001 : 16'h0000;
            else if (tick && samp_n != 16'hffff)
                samp_n <= samp_n + 16'h0001;
            for (int i = 0; i < 3; i++)
            begin
                if (tick)
                    last[i] <= rin[i];
                // A sample landing on the send cycle opens the next interval
                if (send)
                    acc[i] <= tick ? 40'(rin[i]) : 40'sh0000000000; // see RULE_25
                else if (tick)
                    acc[i] <= acc[i] + 40'(rin[i]); // see RULE_14
                if (mode == gyro_out_pkg::MODE_INIT)
                begin
                    integ[i] <= 24'sh000000;
                    rem[i] <= 16'sh0000;
                end
                else if (tick)
                begin
                    integ[i] <= next_integ[i]; // see RULE_16
                    rem[i] <= next_rem[i];
                end
            end
        end
    end

    // Extended error word, rebuilt every cycle
    always_comb
    begin
        next_err = fault_in & ~`ERR_RSV_MASK; // see RULE_01 see RULE_04 see RULE_05
        next_err[`ERR_TX_FAIL] = err_word[`ERR_TX_FAIL];
        if (send)
            next_err[`ERR_TX_FAIL] = !tx_free; // see RULE_02
        next_err[`ERR_MISS_Z] = !rate_ok[2]; // see RULE_03
        next_err[`ERR_MISS_Y] = !rate_ok[1];
        next_err[`ERR_MISS_X] = !rate_ok[0];
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            err_word <= 80'h0;
            err_crc <= 8'h00;
        end
        else
        begin
            err_word <= next_err;
            err_crc <= crc8({term_en ? `ERR_ID_TERM : `ERR_ID_PLAIN, err_word}); // see RULE_23
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            dg_valid <= 1'b0;
            dg <= '0;
        end
        else
        begin
            dg_valid <= send && tx_free;
            if (send && tx_free)
            begin
                dg.val.x <= sel[0];
                dg.val.y <= sel[1];
                dg.val.z <= sel[2];
                // Status from this cycle only, nothing held over
                dg.status <= {|next_err, startup, 3'h0, ~rate_ok}; // see RULE_06 see RULE_22
                dg.latency <= trig_en ? lat_cnt : 16'h0000; // see RULE_13
            end
        end
    end

    // AXI4-Lite write path
    assign wr_go = aw_hold && w_hold && !s_axi_bvalid;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            aw_hold <= 1'b0;
            w_hold <= 1'b0;
            aw_q <= 8'h00;
            wd_q <= 32'h00000000;
            ws_q <= 4'h0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'b00;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_hold <= 1'b1;
                aw_q <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_hold <= 1'b1;
                wd_q <= s_axi_wdata;
                ws_q <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (wr_go)
            begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (aw_q == `A_CTRL || aw_q == `A_DIV) ? 2'b00 : 2'b10;
            end
            if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid <= 1'b0;
                aw_hold <= 1'b0;
                w_hold <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            unit <= gyro_out_pkg::UNIT_RATE;
            trig_en <= 1'b0;
            term_en <= 1'b0;
            out_div <= `DIV_RST;
        end
        else if (wr_go)
        begin
            if (aw_q == `A_CTRL && ws_q[0])
            begin
                unit <= wd_q[1:0];
                trig_en <= wd_q[2];
                term_en <= wd_q[3];
            end
            if (aw_q == `A_DIV)
            begin
                if (ws_q[0])
                    out_div[7:0] <= wd_q[7:0];
                if (ws_q[1])
                    out_div[9:8] <= wd_q[9:8];
            end
        end
    end

    // AXI4-Lite read path
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= 2'b00;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= 2'b00;
            case (s_axi_araddr)
                `A_CTRL: s_axi_rdata <= {28'h0, term_en, trig_en, unit};
                `A_DIV: s_axi_rdata <= {22'h0, out_div};
                `A_STAT: s_axi_rdata <= {27'h0, spec_left, startup, mode};
                `A_LAT: s_axi_rdata <= {16'h0, dg.latency};
                `A_X: s_axi_rdata <= {8'h0, dg.val.x};
                `A_Y: s_axi_rdata <= {8'h0, dg.val.y};
                `A_Z: s_axi_rdata <= {8'h0, dg.val.z};
                `A_ERR0: s_axi_rdata <= err_word[31:0];
                `A_ERR1: s_axi_rdata <= err_word[63:32];
                `A_ERR2: s_axi_rdata <= {16'h0, err_word[79:64]};
                `A_EHDR: s_axi_rdata <= {16'h0, err_crc, term_en ? `ERR_ID_TERM : `ERR_ID_PLAIN};
                default:
                begin
                    s_axi_rdata <= 32'h00000000;
                    s_axi_rresp <= 2'b10;
                end
            endcase
        end
        else if (s_axi_rvalid && s_axi_rready)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    sequence tx_blocked;
        send && !tx_free;
    endsequence

    a_reserved_zero: assert property (@(posedge clk) disable iff (!rst_n)
        err_word[79:60] == 20'h00000) else $error("reserved error bits set"); // see RULE_01
    a_tx_fail_flag: assert property (@(posedge clk) disable iff (!rst_n)
        tx_blocked |=> err_word[`ERR_TX_FAIL] && !dg_valid) else $error("send failure not flagged"); // see RULE_02
    a_missing_flag: assert property (@(posedge clk) disable iff (!rst_n)
        !rate_ok[2] |=> err_word[`ERR_MISS_Z]) else $error("missing Z not flagged"); // see RULE_03
    a_startup_status: assert property (@(posedge clk) disable iff (!rst_n)
        send && tx_free && startup |=> dg_valid && dg.status[`STAT_STARTUP]) else $error("start-up bit missing"); // see RULE_06
    a_svc_no_startup: assert property (@(posedge clk) disable iff (!rst_n)
        mode == gyro_out_pkg::MODE_SERVICE && svc_exit && !reinit |=> !startup && mode == gyro_out_pkg::MODE_NORMAL)
        else $error("start-up after service exit"); // see RULE_08
    a_trig_one_dg: assert property (@(posedge clk) disable iff (!rst_n)
        mode == gyro_out_pkg::MODE_NORMAL && trig_en && trig_fall && tx_free |=> dg_valid ##1 !dg_valid)
        else $error("trigger edge gave no single datagram"); // see RULE_10
    a_service_quiet: assert property (@(posedge clk) disable iff (!rst_n)
        mode == gyro_out_pkg::MODE_SERVICE |-> !send) else $error("datagram in service mode"); // see RULE_12
    a_special_three: assert property (@(posedge clk) disable iff (!rst_n)
        mode == gyro_out_pkg::MODE_INIT && init_done && !reinit && tx_ready[*1] ##0 1'b1 |=> spec_left == `SPECIAL_COUNT)
        else $error("special datagrams not queued"); // see RULE_11
    a_tick_spacing: assert property (@(posedge clk) disable iff (!rst_n)
        tick |=> !tick[*8]) else $error("sample tick too fast"); // see RULE_18
    a_trig_stable: assert property (@(posedge clk) disable iff (!rst_n)
        $fell(trig_st) |-> $past(s2) == 1'b0 && $past(s3) == 1'b0) else $error("edge without two stable samples"); // see RULE_24
endmodule
`default_nettype wire
